// [rtl/adsc_cfg.svh]
// Constants of the converter configuration port: widths, frame counts, offsets, masks, defaults
`ifndef ADSC_CFG_SVH
`define ADSC_CFG_SVH

`define ADSC_DATA_W         16
`define ADSC_ADDR_W         7
`define ADSC_SAMPLE_W       14
`define ADSC_CHANNELS       4
`define ADSC_REG_COUNT      128
`define ADSC_MODE_W         8

// Frame bit counts, counted in serial clock rising edges after select falls, then the reference pulse count a pair needs before its link starts
`define ADSC_CMD_BIT        5'h00
`define ADSC_ADDR_DONE      5'h07
`define ADSC_WRITE_DONE     5'h17
`define ADSC_FRAME_END      5'h18
`define ADSC_SYSREF_PULSES  2'h2

// Field positions
`define ADSC_FOUR_WIRE_BIT  15
`define ADSC_FORMAT_BIT     14
`define ADSC_DEC_AB_BIT     13
`define ADSC_DEC_CD_BIT     10
`define ADSC_SOFT_RST_BIT   0
`define ADSC_SYSREF_SEL_BIT 7
`define ADSC_RESET_AB_BIT   0
`define ADSC_INIT_AB_BIT    1
`define ADSC_RESET_CD_BIT   8
`define ADSC_INIT_CD_BIT    9

// Register offsets
`define ADSC_GENERAL_CONTROL        7'h00
`define ADSC_OVERRANGE_CONFIG       7'h01
`define ADSC_FIXED_WORD_TWO         7'h02
`define ADSC_CLOCK_DIVIDER_SELECT   7'h03
`define ADSC_PIN_AND_SYSREF_DELAY   7'h04
`define ADSC_ANALOG_SLEEP_BY_PIN    7'h05
`define ADSC_ANALOG_SLEEP_BY_PORT   7'h06
`define ADSC_CLOCK_SWITCH_PAIR_ONE  7'h07
`define ADSC_CLOCK_SWITCH_PAIR_TWO  7'h08
`define ADSC_SYSREF_LINK_MODE       7'h0c
`define ADSC_LINK_INIT_RESET        7'h0d
`define ADSC_LANE_ENABLE            7'h0e
`define ADSC_LINK_PARAMS_ONE_A      7'h0f
`define ADSC_LINK_PARAMS_ONE_B      7'h10
`define ADSC_LINK_OPTIONS_ONE       7'h13
`define ADSC_LINK_PARAMS_TWO_A      7'h16
`define ADSC_LINK_PARAMS_TWO_B      7'h17
`define ADSC_LINK_OPTIONS_TWO       7'h1a
`define ADSC_TEST_PATTERN_CONTROL   7'h1d
`define ADSC_LINK_SLEEP_BY_PIN      7'h1e
`define ADSC_LINK_SLEEP_BY_PORT     7'h1f
`define ADSC_LANE_POLARITY_PRBS     7'h20
`define ADSC_PRBS_AND_VREF_SELECT   7'h21
`define ADSC_TRIM_WORD_A            7'h44
`define ADSC_TRIM_WORD_B            7'h47
`define ADSC_TRIM_WORD_C            7'h4c
`define ADSC_TRIM_WORD_D            7'h50
`define ADSC_TRIM_WORD_E            7'h51
`define ADSC_TRIM_WORD_F            7'h54
`define ADSC_TRIM_WORD_G            7'h59
`define ADSC_TRIM_WORD_H            7'h5d
`define ADSC_TEMPERATURE_READING    7'h63
`define ADSC_DRIVER_EMPHASIS_ONE    7'h64
`define ADSC_DRIVER_CURRENT_ONE     7'h67

// Default values (fixed bits included)
`define ADSC_RST_ZERO          16'h0000
`define ADSC_RST_OVERRANGE     16'haf7a
`define ADSC_RST_FIXED_TWO     16'h4000
`define ADSC_RST_CLOCK_DIV     16'h4040
`define ADSC_RST_PIN_DELAY     16'h000f
`define ADSC_RST_ALL_ONES      16'hffff
`define ADSC_RST_CLOCK_SWITCH  16'h0144
`define ADSC_RST_SYSREF_MODE   16'h31c0

// Writable bit masks; bits outside a mask keep their fixed value
`define ADSC_MSK_NONE          16'h0000
`define ADSC_MSK_FULL          16'hffff
`define ADSC_MSK_GENERAL       16'hf601
`define ADSC_MSK_OVERRANGE     16'h8ffc
`define ADSC_MSK_CLOCK_DIV     16'h77f7
`define ADSC_MSK_PIN_DELAY     16'hff0c
`define ADSC_MSK_CLOCK_SWITCH  16'h0200
`define ADSC_MSK_SYSREF_MODE   16'h003f
`define ADSC_MSK_LINK_INIT     16'h0303
`define ADSC_MSK_LANE_ENABLE   16'h00ff
`define ADSC_MSK_PARAMS_A      16'h0303
`define ADSC_MSK_PARAMS_B      16'h03e3
`define ADSC_MSK_OPTIONS       16'h0070
`define ADSC_MSK_TEST_PATTERN  16'h0068
`define ADSC_MSK_LINK_SLEEP    16'h03ff
`define ADSC_MSK_PRBS_VREF     16'h6007
`define ADSC_MSK_EMPHASIS      16'hfff0

`endif

// [rtl/adsc_pkg.sv]
// Types shared by the converter configuration port and its sample formatter
`include "adsc_cfg.svh"

package adsc_pkg;

  // One converter sample as it leaves the core, 2s complement
  typedef struct packed {
    logic                      valid;
    logic                      overRangeFlag;
    logic [`ADSC_SAMPLE_W-1:0] data;
  } adsc_sample_type;

  // One formatted output word
  typedef struct packed {
    logic                    valid;
    logic [`ADSC_DATA_W-1:0] word;
  } adsc_word_type;

  // Configuration bits that cross from the serial clock to the system clock
  typedef struct packed {
    logic offsetBin;
    logic decAb;
    logic decCd;
    logic sysrefSelCd;
    logic initAb;
    logic resetAb;
    logic initCd;
    logic resetCd;
  } adsc_mode_type;

endpackage

// [rtl/adsc_sample_fmt.sv]
// Output word formatter for one converter channel
`include "adsc_cfg.svh"

module adsc_sample_fmt (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     decimate,
  input  wire logic                     offsetBin,
  input  wire adsc_pkg::adsc_sample_type sampleIn,
  output adsc_pkg::adsc_word_type       wordOut
);
  import adsc_pkg::*;

  logic          phase_q;
  adsc_word_type word_q;
  wire           keep;
  wire [`ADSC_DATA_W-1:0] packed16;

  // Decimation keeps every second sample, halving the rate; the filter itself lives upstream
  assign keep     = sampleIn.valid & (~decimate | ~phase_q);
  // Sample MSB aligned, over-range next, bit 0 zero; offset binary flips the sign bit
  assign packed16 = {sampleIn.data[`ADSC_SAMPLE_W-1] ^ offsetBin,
                     sampleIn.data[`ADSC_SAMPLE_W-2:0], sampleIn.overRangeFlag, 1'b0};

  // Phase toggles on each valid sample so the kept samples stay evenly spaced
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= 1'b0;
      word_q  <= '0;
    end else begin
      if (sampleIn.valid) phase_q <= ~phase_q;
      word_q.valid <= keep;
      if (keep) word_q.word <= packed16;
    end
  end

  assign wordOut = word_q;

endmodule

// [rtl/adsc_serial_port.sv]
// Serial configuration port, register bank, link-init sequencing and output words of the converter
`include "adsc_cfg.svh"

module adsc_serial_port (
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  input  wire logic                          serialClk,
  input  wire logic                          serialSelect_n,
  input  wire logic                          hardResetPin_n,
  input  wire logic                          serialIoIn,
  output logic                               serialIoOut,
  output logic                               serialIoOe,
  output logic                               serialOutLine,
  output logic                               serialOutOe,
  input  wire logic                          sysrefAb,
  input  wire logic                          sysrefCd,
  input  wire adsc_pkg::adsc_sample_type [3:0] sampleIn,
  output adsc_pkg::adsc_word_type [3:0]      wordOut,
  output logic [1:0]                         dualLanePair,
  output logic [1:0]                         linkResetPairBits,
  output logic [1:0]                         linkInitPairBits,
  output logic [1:0]                         linkStartPair
);
  import adsc_pkg::*;

  // ---------------- serial clock domain ----------------
  logic [`ADSC_DATA_W-1:0] regFile_q [0:`ADSC_REG_COUNT-1];
  logic [4:0]              bitCount_q;
  logic [14:0]             shiftIn_q;
  logic                    readCmd_q;
  logic [`ADSC_ADDR_W-1:0] addr_q;
  logic                    readPhase_q;
  logic [`ADSC_DATA_W-1:0] readShift_q;
  logic                    outBit_q;
  logic                    outEn_q;

  wire                     bankRst_n;
  wire                     frameRst_n;
  wire                     addrDone;
  wire                     writeNow;
  wire                     softResetHit;
  wire                     fourWire;
  wire [`ADSC_ADDR_W-1:0]  addrNow;
  wire [`ADSC_DATA_W-1:0]  dataNow;
  wire [`ADSC_DATA_W-1:0]  writeMask;
  wire [`ADSC_DATA_W-1:0]  mergedWord;

  // Default value of each address; unmapped addresses hold zero
  function automatic logic [`ADSC_DATA_W-1:0] regReset(input logic [`ADSC_ADDR_W-1:0] a);
    case (a)
      `ADSC_OVERRANGE_CONFIG:     regReset = `ADSC_RST_OVERRANGE;
      `ADSC_FIXED_WORD_TWO:       regReset = `ADSC_RST_FIXED_TWO;
      `ADSC_CLOCK_DIVIDER_SELECT: regReset = `ADSC_RST_CLOCK_DIV;
      `ADSC_PIN_AND_SYSREF_DELAY: regReset = `ADSC_RST_PIN_DELAY;
      `ADSC_ANALOG_SLEEP_BY_PORT,
      `ADSC_LINK_SLEEP_BY_PORT:   regReset = `ADSC_RST_ALL_ONES;
      `ADSC_CLOCK_SWITCH_PAIR_ONE,
      `ADSC_CLOCK_SWITCH_PAIR_TWO: regReset = `ADSC_RST_CLOCK_SWITCH;
      `ADSC_SYSREF_LINK_MODE:     regReset = `ADSC_RST_SYSREF_MODE;
      default:                    regReset = `ADSC_RST_ZERO;
    endcase
  endfunction

  // Writable bits of each address; unmapped and read-only words take no writes
  function automatic logic [`ADSC_DATA_W-1:0] regMask(input logic [`ADSC_ADDR_W-1:0] a);
    case (a)
      `ADSC_GENERAL_CONTROL:      regMask = `ADSC_MSK_GENERAL;
      `ADSC_OVERRANGE_CONFIG:     regMask = `ADSC_MSK_OVERRANGE;
      `ADSC_CLOCK_DIVIDER_SELECT: regMask = `ADSC_MSK_CLOCK_DIV;
      `ADSC_PIN_AND_SYSREF_DELAY: regMask = `ADSC_MSK_PIN_DELAY;
      `ADSC_CLOCK_SWITCH_PAIR_ONE,
      `ADSC_CLOCK_SWITCH_PAIR_TWO: regMask = `ADSC_MSK_CLOCK_SWITCH;
      `ADSC_SYSREF_LINK_MODE:     regMask = `ADSC_MSK_SYSREF_MODE;
      `ADSC_LINK_INIT_RESET:      regMask = `ADSC_MSK_LINK_INIT;
      `ADSC_LANE_ENABLE:          regMask = `ADSC_MSK_LANE_ENABLE;
      `ADSC_LINK_PARAMS_ONE_A,
      `ADSC_LINK_PARAMS_TWO_A:    regMask = `ADSC_MSK_PARAMS_A;
      `ADSC_LINK_PARAMS_ONE_B,
      `ADSC_LINK_PARAMS_TWO_B:    regMask = `ADSC_MSK_PARAMS_B;
      `ADSC_LINK_OPTIONS_ONE,
      `ADSC_LINK_OPTIONS_TWO:     regMask = `ADSC_MSK_OPTIONS;
      `ADSC_TEST_PATTERN_CONTROL: regMask = `ADSC_MSK_TEST_PATTERN;
      `ADSC_LINK_SLEEP_BY_PIN,
      `ADSC_LINK_SLEEP_BY_PORT:   regMask = `ADSC_MSK_LINK_SLEEP;
      `ADSC_PRBS_AND_VREF_SELECT: regMask = `ADSC_MSK_PRBS_VREF;
      `ADSC_DRIVER_EMPHASIS_ONE:  regMask = `ADSC_MSK_EMPHASIS;
      `ADSC_ANALOG_SLEEP_BY_PIN, `ADSC_ANALOG_SLEEP_BY_PORT,
      `ADSC_LANE_POLARITY_PRBS,  `ADSC_DRIVER_CURRENT_ONE,
      `ADSC_TRIM_WORD_A, `ADSC_TRIM_WORD_B, `ADSC_TRIM_WORD_C, `ADSC_TRIM_WORD_D,
      `ADSC_TRIM_WORD_E, `ADSC_TRIM_WORD_F, `ADSC_TRIM_WORD_G,
      `ADSC_TRIM_WORD_H:          regMask = `ADSC_MSK_FULL;
      default:                    regMask = `ADSC_MSK_NONE;
    endcase
  endfunction

  // Resets: the bank loads its defaults on system or pin reset, the frame logic clears also while select is high.
  // The serial clock stops between frames, so both must act without it.
  assign bankRst_n  = rst_n & hardResetPin_n;
  assign frameRst_n = bankRst_n & ~serialSelect_n;

  // Frame decode
  assign addrNow      = {shiftIn_q[5:0], serialIoIn};
  assign dataNow      = {shiftIn_q[14:0], serialIoIn};
  assign addrDone     = (bitCount_q == `ADSC_ADDR_DONE);
  assign writeNow     = (bitCount_q == `ADSC_WRITE_DONE) & ~readCmd_q;
  assign softResetHit = writeNow & (addr_q == `ADSC_GENERAL_CONTROL)
                        & dataNow[`ADSC_SOFT_RST_BIT];
  assign writeMask    = regMask(addr_q);
  assign mergedWord   = (regFile_q[addr_q] & ~writeMask) | (dataNow & writeMask);
  assign fourWire     = regFile_q[`ADSC_GENERAL_CONTROL][`ADSC_FOUR_WIRE_BIT];

  // Frame shifter: counts rising edges, latches command and address, loads read data.
  // Edges past the last data bit are ignored until select returns high.
  always_ff @(posedge serialClk or negedge frameRst_n) begin
    if (!frameRst_n) begin
      bitCount_q  <= '0;
      shiftIn_q   <= '0;
      readCmd_q   <= 1'b0;
      addr_q      <= '0;
      readPhase_q <= 1'b0;
      readShift_q <= '0;
    end else begin
      if (bitCount_q != `ADSC_FRAME_END) bitCount_q <= bitCount_q + 5'h01;
      shiftIn_q <= {shiftIn_q[13:0], serialIoIn};
      if (bitCount_q == `ADSC_CMD_BIT) readCmd_q <= serialIoIn;
      if (addrDone) begin
        addr_q      <= addrNow;
        readPhase_q <= readCmd_q;
        readShift_q <= regFile_q[addrNow];
      end else if (readPhase_q) begin
        readShift_q <= {readShift_q[14:0], 1'b0};
      end
      if (bitCount_q == `ADSC_WRITE_DONE) readPhase_q <= 1'b0;
    end
  end

  // Register bank. A soft reset loads defaults instead of storing, so its bit reads zero.
  always_ff @(posedge serialClk or negedge bankRst_n) begin
    if (!bankRst_n) begin
      for (int i = 0; i < `ADSC_REG_COUNT; i++) regFile_q[i] <= regReset(7'(i));
    end else if (softResetHit) begin
      for (int i = 0; i < `ADSC_REG_COUNT; i++) regFile_q[i] <= regReset(7'(i));
    end else if (writeNow) begin
      regFile_q[addr_q] <= mergedWord;
    end
  end

  // Read data leaves on the falling edge so it is stable at the controller's rising edge
  always_ff @(negedge serialClk or negedge frameRst_n) begin
    if (!frameRst_n) begin
      outBit_q <= 1'b0;
      outEn_q  <= 1'b0;
    end else begin
      outBit_q <= readShift_q[`ADSC_DATA_W-1];
      outEn_q  <= readPhase_q;
    end
  end

  // Read-back line chosen by the wire-mode bit; the data line floats outside read data
  assign serialIoOut   = outBit_q;
  assign serialOutLine = outBit_q;
  assign serialIoOe    = outEn_q & ~fourWire;
  assign serialOutOe   = outEn_q & fourWire;

  // ---------------- system clock domain ----------------
  adsc_mode_type            modeRaw;
  adsc_mode_type            mode;
  logic [`ADSC_MODE_W+1:0]  sync1_q;
  logic [`ADSC_MODE_W+1:0]  sync2_q;
  logic [1:0]               sysrefPrev_q;
  logic [1:0]               sysrefSync;
  logic [1:0]               pairReset;
  logic [1:0]               pairInit;
  logic [1:0]               pairSysref;
  logic [1:0]               startPair_q;
  logic [1:0]               pulseCount_q [0:1];
  wire  [`ADSC_MODE_W+1:0]  syncIn;

  // Quasi-static fields straight from bank flops; bits written together may land
  // one system clock apart, harmless since the link steps are separate writes
  assign modeRaw.offsetBin   = regFile_q[`ADSC_GENERAL_CONTROL][`ADSC_FORMAT_BIT];
  assign modeRaw.decAb       = regFile_q[`ADSC_GENERAL_CONTROL][`ADSC_DEC_AB_BIT];
  assign modeRaw.decCd       = regFile_q[`ADSC_GENERAL_CONTROL][`ADSC_DEC_CD_BIT];
  assign modeRaw.sysrefSelCd = regFile_q[`ADSC_CLOCK_DIVIDER_SELECT][`ADSC_SYSREF_SEL_BIT];
  assign modeRaw.initAb      = regFile_q[`ADSC_LINK_INIT_RESET][`ADSC_INIT_AB_BIT];
  assign modeRaw.resetAb     = regFile_q[`ADSC_LINK_INIT_RESET][`ADSC_RESET_AB_BIT];
  assign modeRaw.initCd      = regFile_q[`ADSC_LINK_INIT_RESET][`ADSC_INIT_CD_BIT];
  assign modeRaw.resetCd     = regFile_q[`ADSC_LINK_INIT_RESET][`ADSC_RESET_CD_BIT];
  assign syncIn              = {sysrefCd, sysrefAb, modeRaw};

  // Two-flop synchroniser for every crossing bit and both reference pins
  genvar b;
  generate
    for (b = 0; b < `ADSC_MODE_W + 2; b++) begin : g_sync
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          sync1_q[b] <= 1'b0;
          sync2_q[b] <= 1'b0;
        end else begin
          sync1_q[b] <= syncIn[b];
          sync2_q[b] <= sync1_q[b];
        end
      end
    end
  endgenerate

  // Synchronised view; pair CD may take its reference from the AB pin
  assign mode          = sync2_q[`ADSC_MODE_W-1:0];
  assign sysrefSync    = sync2_q[`ADSC_MODE_W+1:`ADSC_MODE_W];
  assign pairReset     = {mode.resetCd, mode.resetAb};
  assign pairInit      = {mode.initCd, mode.initAb};
  assign pairSysref[0] = sysrefSync[0];
  assign pairSysref[1] = mode.sysrefSelCd ? sysrefSync[1] : sysrefSync[0];

  // Per pair: reference pulses counted while the reset bit is set, up to two;
  // the link starts once both are seen and init is cleared
  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_pair
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          sysrefPrev_q[p]    <= 1'b0;
          pulseCount_q[p]    <= '0;
          startPair_q[p]     <= 1'b0;
        end else begin
          sysrefPrev_q[p] <= pairSysref[p];
          if (!pairReset[p]) begin
            pulseCount_q[p] <= '0;
          end else if (pairSysref[p] & ~sysrefPrev_q[p] &
                       (pulseCount_q[p] != `ADSC_SYSREF_PULSES)) begin
            pulseCount_q[p] <= pulseCount_q[p] + 2'h1;
          end
          startPair_q[p] <= pairReset[p] & ~pairInit[p] &
                            (pulseCount_q[p] == `ADSC_SYSREF_PULSES);
        end
      end
    end
  endgenerate

  assign linkResetPairBits = pairReset;
  assign linkInitPairBits  = pairInit;
  assign linkStartPair     = startPair_q;
  assign dualLanePair      = {~mode.decCd, ~mode.decAb};

  // One formatter per channel; channels 0,1 form pair AB and 2,3 pair CD
  genvar c;
  generate
    for (c = 0; c < `ADSC_CHANNELS; c++) begin : g_chan
      adsc_sample_fmt u_fmt (
        .clk      (clk),
        .rst_n    (rst_n),
        .decimate ((c < 2) ? mode.decAb : mode.decCd),
        .offsetBin(mode.offsetBin),
        .sampleIn (sampleIn[c]),
        .wordOut  (wordOut[c])
      );
    end
  endgenerate

endmodule

// [sim/adsc_port_checker.sv]
// Concurrent checks on the serial port outputs and the sample words
module adsc_port_checker (
  input wire logic                            clk,
  input wire logic                            rst_n,
  input wire logic                            serialSelect_n,
  input wire logic                            serialIoOe,
  input wire logic                            serialOutOe,
  input wire adsc_pkg::adsc_sample_type [3:0] sampleIn,
  input wire adsc_pkg::adsc_word_type [3:0]   wordOut,
  input wire logic [1:0]                      dualLanePair,
  input wire logic [1:0]                      linkResetPairBits,
  input wire logic [1:0]                      linkInitPairBits,
  input wire logic [1:0]                      linkStartPair
);
  timeunit 1ns;
  timeprecision 1ps;
  import adsc_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Three cycles margin covers the lag of the synced mode bits
  sequence decSteady;
    !dualLanePair[0] [*3];
  endsequence
  sequence bypSteady;
    dualLanePair[0] [*3];
  endsequence
  chk_oe_single: assert property (!(serialIoOe && serialOutOe))
    else $error("both serial outputs enabled");
  chk_oe_idle: assert property (serialSelect_n |-> !serialIoOe && !serialOutOe)
    else $error("serial output driven outside a frame");
  chk_io_stands: assert property ($rose(serialIoOe) |-> serialIoOe [*8])
    else $error("data line drive cut short");
  chk_out_stands: assert property ($rose(serialOutOe) |-> serialOutOe [*8])
    else $error("output line drive cut short");
  chk_word_fmt: assert property (wordOut[0].valid |-> $past(sampleIn[0].valid)
    && wordOut[0].word[14:0] == {$past(sampleIn[0].data[12:0]),
    $past(sampleIn[0].overRangeFlag), 1'b0}) else $error("output word layout wrong");
  chk_dec_drop: assert property (decSteady ##0 wordOut[0].valid |=> !wordOut[0].valid)
    else $error("decimation kept two samples in a row");
  chk_byp_keep: assert property (bypSteady ##0 sampleIn[0].valid |=> wordOut[0].valid)
    else $error("bypass dropped a sample");
  chk_start_cond: assert property ($rose(linkStartPair[0])
    |-> $past(linkResetPairBits[0]) && !$past(linkInitPairBits[0]))
    else $error("link start without reset set and init clear");
endmodule

bind adsc_serial_port adsc_port_checker u_chk (
  .clk, .rst_n, .serialSelect_n, .serialIoOe, .serialOutOe, .sampleIn, .wordOut,
  .dualLanePair, .linkResetPairBits, .linkInitPairBits, .linkStartPair
);

// [sim/adsc_ctrl_model.sv]
// Model of the external controller that runs frames on the serial port
module adsc_ctrl_model (
  output logic      serialClk,
  output logic      serialSelect_n,
  output wire logic serialIoIn,
  input  wire logic serialIoOut,
  input  wire logic serialIoOe,
  input  wire logic serialOutLine,
  input  wire logic serialOutOe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drvBit;
  // Line level: device while it drives, else our bit; a released line shows the inverse
  assign serialIoIn = serialIoOe ? serialIoOut : drvBit;
  initial begin
    serialClk = 1'b0;
    serialSelect_n = 1'b1;
    drvBit = 1'b0;
  end
  // One frame; clock stands low outside it and runs at 160 ns period
  task automatic frame(input logic rd, input logic [6:0] a, input logic [15:0] wd,
                       output logic [15:0] rdata);
    logic [23:0] bits;
    bits = {rd, a, wd};
    rdata = 16'h0000;
    #13 serialSelect_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      if (rd && i == 15) drvBit = ~drvBit;
      else if (!rd || i > 15) drvBit = bits[i];
      #80 serialClk = 1'b1;
      rdata = {rdata[14:0], serialOutOe ? serialOutLine : serialIoIn};
      #80 serialClk = 1'b0;
    end
    serialSelect_n = 1'b1;
    #160;
  endtask
endmodule

// [sim/adsc_serial_port_tb.sv]
// Self-checking bench for the converter serial configuration port
module adsc_serial_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import adsc_pkg::*;
  logic clk, rst_n, hardResetPin_n, sysrefAb, sysrefCd;
  wire logic serialClk, serialSelect_n, serialIoIn, serialIoOut, serialIoOe;
  wire logic serialOutLine, serialOutOe;
  adsc_sample_type [3:0] sampleIn;
  adsc_word_type [3:0] wordOut;
  wire logic [1:0] dualLanePair, linkResetPairBits, linkInitPairBits, linkStartPair;
  int failures, comparisons, cycles, kept;
  logic [6:0] defA [9] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h06, 7'h0c, 7'h1f, 7'h7f};
  logic [15:0] defV [9] = '{16'h0000, 16'haf7a, 16'h4000, 16'h4040, 16'h000f, 16'hffff,
                            16'h31c0, 16'hffff, 16'h0000};
  adsc_serial_port u_dut (.clk, .rst_n, .serialClk, .serialSelect_n, .hardResetPin_n,
    .serialIoIn, .serialIoOut, .serialIoOe, .serialOutLine, .serialOutOe, .sysrefAb,
    .sysrefCd, .sampleIn, .wordOut, .dualLanePair, .linkResetPairBits, .linkInitPairBits,
    .linkStartPair);
  adsc_ctrl_model u_ctrl (.serialClk, .serialSelect_n, .serialIoIn, .serialIoOut,
    .serialIoOe, .serialOutLine, .serialOutOe);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Hang guard: the sequence needs roughly 20000 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      wrap_up();
    end
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    logic [15:0] r;
    u_ctrl.frame(1'b0, a, d, r);
  endtask
  task automatic rdc(input logic [6:0] a, input logic [15:0] exp);
    logic [15:0] r;
    u_ctrl.frame(1'b1, a, 16'h0000, r);
    chk("register", exp, r);
  endtask
  // Caller is on a falling edge; valid stays up across back-to-back calls
  task automatic smp(input logic [13:0] d, input logic ov, input logic fmt);
    sampleIn = {4{1'b1, ov, d}};
    @(negedge clk);
    for (int c = 0; c < 4; c++) begin
      if (wordOut[c].valid === 1'b1) begin
        kept++;
        chk("word", {d[13] ^ fmt, d[12:0], ov, 1'b0}, wordOut[c].word);
      end
    end
  endtask
  task automatic pulse_hard();
    @(negedge clk) hardResetPin_n = 1'b0;
    #16 hardResetPin_n = 1'b1;
  endtask
  // Full link init; expStart names the pairs whose reference comes from the AB pin
  task automatic link_init(input logic [1:0] expStart);
    wr(7'h0d, 16'h0000);
    wr(7'h0d, 16'h0202);
    wr(7'h0d, 16'h0303);
    repeat (8) @(negedge clk);
    chk("init", 16'h0003, {14'h0, linkInitPairBits});
    chk("reset", 16'h0003, {14'h0, linkResetPairBits});
    wr(7'h0d, 16'h0202);
    wr(7'h0d, 16'h0303);
    for (int i = 0; i < 2; i++) begin
      @(negedge clk) sysrefAb = 1'b1;
      repeat (4) @(negedge clk);
      sysrefAb = 1'b0;
      repeat (4) @(negedge clk);
    end
    chk("start early", 16'h0000, {14'h0, linkStartPair});
    wr(7'h0d, 16'h0101);
    repeat (8) @(negedge clk);
    chk("start", {14'h0, expStart}, {14'h0, linkStartPair});
  endtask
  task automatic wrap_up();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    hardResetPin_n = 1'b1;
    sysrefAb = 1'b0;
    sysrefCd = 1'b0;
    sampleIn = '0;
    repeat (12) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    pulse_hard();
    for (int i = 0; i < 9; i++) rdc(defA[i], defV[i]);
    // Fixed bits keep their value whatever is written
    wr(7'h01, 16'h0000);
    rdc(7'h01, 16'h2002);
    wr(7'h02, 16'hffff);
    rdc(7'h02, 16'h4000);
    wr(7'h44, 16'h0074);
    wr(7'h06, 16'hffdf);
    rdc(7'h44, 16'h0074);
    rdc(7'h06, 16'hffdf);
    wr(7'h47, 16'h0074);
    rdc(7'h47, 16'h0074);
    wr(7'h00, 16'h0001);
    rdc(7'h00, 16'h0000);
    rdc(7'h44, 16'h0000);
    wr(7'h4c, 16'h4000);
    pulse_hard();
    rdc(7'h4c, 16'h0000);
    // Link init sequence, two reference pulses while reset is held
    link_init(2'b11);
    // Bypass keeps every sample, decimation every other one
    chk("lanes", 16'h0003, {14'h0, dualLanePair});
    kept = 0;
    @(negedge clk);
    smp(14'h2a5c, 1'b1, 1'b0);
    sampleIn = '0;
    chk("bypass kept", 16'h0004, 16'(kept));
    wr(7'h00, 16'h6400);
    repeat (8) @(negedge clk);
    chk("lanes", 16'h0000, {14'h0, dualLanePair});
    kept = 0;
    for (int i = 0; i < 8; i++) smp({11'h400, 3'(i)}, i[0], 1'b1);
    sampleIn = '0;
    chk("dec kept", 16'h0010, 16'(kept));
    // A clock setting change needs a fresh init; pair CD now waits for its own pin
    wr(7'h03, 16'h40c0);
    link_init(2'b01);
    // Switch to the dedicated output line; fixed bits 6..5 must not stick
    wr(7'h00, 16'h8060);
    rdc(7'h01, 16'haf7a);
    rdc(7'h00, 16'h8000);
    wrap_up();
  end
endmodule
